// ---- src/adc_post_top.sv ----
// Post-conversion gain, input swap and test pattern stage
`timescale 1ns/1ps
`default_nettype none
`include "adc_post_cfg.svh"

module adc_post_top #(
   parameter int BRANCHES = 8,
   parameter int LANES = 4
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic SCTRL_SEL_N,
   input wire logic SCTRL_CLK,
   input wire logic SCTRL_DATA,
   input wire logic SINGLE_MODE,
   input wire adc_post_pkg::lane_set_t SAMPLE_IN,
   input wire logic LINK_CLOCK,
   output adc_post_pkg::lane_codes_t LANE_OUT,
   output logic LANE_NEW,
   output logic [1:0] DUAL_INPUT_SWAP,
   output logic SINGLE_INPUT_SWAP,
   output logic PATTERN_ACTIVE
);

   if (BRANCHES != 8) $error("register map holds eight trim codes");
   if (LANES != 4) $error("lane set is four lanes wide");

   // Channel of a lane in dual mode: lower half first channel
   function automatic logic lane_chan(input int lane);
      return (lane >= LANES / 2);
   endfunction

   // ----------------------------------------------------------
   // Serial control port
   // ----------------------------------------------------------
   adc_post_pkg::spi_state_t spi_state_r, spi_state_nxt;
   logic [2:0] pin_s1_r, pin_s2_r, pin_s3_r;
   logic [`SPI_FRAME_BITS-1:0] shift_r, shift_nxt;
   logic [4:0] count_r, count_nxt;
   logic wr_en;
   logic sclk_rise;
   logic [7:0] wr_addr;
   logic [15:0] wr_data;

   always_comb begin
      spi_state_nxt = spi_state_r;
      shift_nxt = shift_r;
      count_nxt = count_r;
      wr_en = 1'b0;
      sclk_rise = pin_s2_r[1] & ~pin_s3_r[1];
      unique case (spi_state_r)
         adc_post_pkg::SPI_IDLE: begin
            count_nxt = '0;
            if (!pin_s2_r[0]) begin
               spi_state_nxt = adc_post_pkg::SPI_SHIFT;
            end
         end
         adc_post_pkg::SPI_SHIFT: begin
            if (pin_s2_r[0]) begin
               spi_state_nxt = adc_post_pkg::SPI_IDLE;
               wr_en = (count_r == 5'(`SPI_FRAME_BITS));
            end else if (sclk_rise && count_r != `SPI_COUNT_MAX) begin
               shift_nxt = {shift_r[`SPI_FRAME_BITS-2:0], pin_s2_r[2]};
               count_nxt = count_r + 5'h01;
            end
         end
         default: begin
            spi_state_nxt = adc_post_pkg::SPI_IDLE;
         end
      endcase
   end

   assign wr_addr = shift_r[`SPI_FRAME_BITS-1:`SPI_ADDR_LSB];
   assign wr_data = shift_r[`SPI_ADDR_LSB-1:0];

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         spi_state_r <= adc_post_pkg::SPI_IDLE;
         pin_s1_r <= 3'h1;
         pin_s2_r <= 3'h1;
         pin_s3_r <= 3'h1;
         shift_r <= '0;
         count_r <= '0;
      end else begin
         spi_state_r <= spi_state_nxt;
         pin_s1_r <= {SCTRL_DATA, SCTRL_CLK, SCTRL_SEL_N};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         shift_r <= shift_nxt;
         count_r <= count_nxt;
      end
   end

   // ----------------------------------------------------------
   // Register file
   // ----------------------------------------------------------
   logic [1:0] dual_swap_r, dual_swap_nxt;
   logic single_swap_r, single_swap_nxt;
   logic [2:0] patsel_r, patsel_nxt;
   logic [7:0] pat1_r, pat1_nxt;
   logic [7:0] pat2_r, pat2_nxt;
   logic [1:0][3:0] dual_coarse_r, dual_coarse_nxt;
   logic [3:0] single_coarse_r, single_coarse_nxt;
   logic step_x_r, step_x_nxt;
   logic trim_en_r, trim_en_nxt;
   logic [BRANCHES-1:0][`TRIM_W-1:0] trim_r, trim_nxt;
   logic [1:0] trim_idx;

   always_comb begin
      dual_swap_nxt = dual_swap_r;
      single_swap_nxt = single_swap_r;
      patsel_nxt = patsel_r;
      pat1_nxt = pat1_r;
      pat2_nxt = pat2_r;
      dual_coarse_nxt = dual_coarse_r;
      single_coarse_nxt = single_coarse_r;
      step_x_nxt = step_x_r;
      trim_en_nxt = trim_en_r;
      trim_nxt = trim_r;
      trim_idx = 2'(wr_addr - `ADDR_TRIM_LO);
      if (wr_en) begin
         unique case (wr_addr)
            `ADDR_SWAP: begin
               dual_swap_nxt =
                  wr_data[`SWAP_DUAL_MSB:`SWAP_DUAL_LSB];
               single_swap_nxt = wr_data[`SWAP_SINGLE_BIT];
            end
            `ADDR_PATSEL: begin
               patsel_nxt = wr_data[`PATSEL_MSB:`PATSEL_LSB];
            end
            `ADDR_PAT1: begin
               pat1_nxt = wr_data[`PATCODE_MSB:`PATCODE_LSB];
            end
            `ADDR_PAT2: begin
               pat2_nxt = wr_data[`PATCODE_MSB:`PATCODE_LSB];
            end
            `ADDR_COARSE: begin
               dual_coarse_nxt[0] =
                  wr_data[`COARSE_D1_LSB+:`COARSE_W];
               dual_coarse_nxt[1] = wr_data[`COARSE_D2_LSB+:`COARSE_W];
               single_coarse_nxt = wr_data[`COARSE_S_LSB+:`COARSE_W];
            end
            `ADDR_GAINCFG: begin
               step_x_nxt = wr_data[`GAINCFG_STEP_BIT];
               trim_en_nxt = wr_data[`GAINCFG_TRIM_BIT];
            end
            default: begin
               if (wr_addr >= `ADDR_TRIM_LO && wr_addr <= `ADDR_TRIM_HI) begin
                  trim_nxt[{trim_idx, 1'b0}] =
                     wr_data[`TRIM_ODD_LSB+:`TRIM_W];
                  trim_nxt[{trim_idx, 1'b1}] =
                     wr_data[`TRIM_EVEN_LSB+:`TRIM_W];
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         dual_swap_r <= 2'h0;
         single_swap_r <= 1'b0;
         patsel_r <= `PATSEL_RESET;
         pat1_r <= `CODE_RESET;
         pat2_r <= `CODE_RESET;
         dual_coarse_r <= {2{`COARSE_RESET}};
         single_coarse_r <= `COARSE_RESET;
         step_x_r <= 1'b0;
         trim_en_r <= 1'b0;
         trim_r <= {BRANCHES{`TRIM_RESET}};
      end else begin
         dual_swap_r <= dual_swap_nxt;
         single_swap_r <= single_swap_nxt;
         patsel_r <= patsel_nxt;
         pat1_r <= pat1_nxt;
         pat2_r <= pat2_nxt;
         dual_coarse_r <= dual_coarse_nxt;
         single_coarse_r <= single_coarse_nxt;
         step_x_r <= step_x_nxt;
         trim_en_r <= trim_en_nxt;
         trim_r <= trim_nxt;
      end
   end

   assign DUAL_INPUT_SWAP = dual_swap_r;
   assign SINGLE_INPUT_SWAP = single_swap_r;

   // ----------------------------------------------------------
   // Gain lanes
   // ----------------------------------------------------------
   adc_post_pkg::lane_ctrl_t [LANES-1:0] lane_ctrl;
   adc_post_pkg::lane_codes_t gain_codes;

   for (genvar g = 0; g < LANES; g++) begin : g_lane
      always_comb begin
         lane_ctrl[g].step_x = step_x_r;
         lane_ctrl[g].trim_en = trim_en_r;
         if (SINGLE_MODE) begin
            lane_ctrl[g].coarse = single_coarse_r;
            lane_ctrl[g].swap = single_swap_r;
         end else begin
            lane_ctrl[g].coarse = dual_coarse_r[lane_chan(g)];
            lane_ctrl[g].swap = dual_swap_r[lane_chan(g)];
         end
      end

      gain_stage #(
         .CODE_W(8)
      ) u_gain (
         .clk(CLOCK),
         .rst(RST),
         .ctrl(lane_ctrl[g]),
         .trim(trim_r[SAMPLE_IN[g].branch]),
         .code_in(SAMPLE_IN[g].code),
         .code_r(gain_codes[g])
      );
   end

   // ----------------------------------------------------------
   // Test patterns and output select
   // ----------------------------------------------------------
   adc_post_pkg::pattern_mode_t mode;
   logic [7:0] ramp_r, ramp_nxt;
   logic alt_r, alt_nxt;
   logic active_r, active_nxt;
   adc_post_pkg::lane_codes_t lanes_r, lanes_nxt;

   always_comb begin
      unique case (patsel_r)
         `PATSEL_RAMP: mode = adc_post_pkg::PAT_RAMP;
         `PATSEL_ALT: mode = adc_post_pkg::PAT_ALT;
         default: mode = adc_post_pkg::PAT_NORMAL;
      endcase
   end

   always_comb begin
      ramp_nxt = '0;
      alt_nxt = 1'b0;
      active_nxt = 1'b0;
      lanes_nxt = gain_codes;
      unique case (mode)
         adc_post_pkg::PAT_RAMP: begin
            ramp_nxt = ramp_r + 8'h01;
            active_nxt = 1'b1;
            lanes_nxt = {LANES{ramp_r}};
         end
         adc_post_pkg::PAT_ALT: begin
            alt_nxt = ~alt_r;
            active_nxt = 1'b1;
            lanes_nxt = {LANES{alt_r ? pat2_r : pat1_r}};
         end
         adc_post_pkg::PAT_NORMAL: begin
            active_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         ramp_r <= `CODE_RESET;
         alt_r <= 1'b0;
         active_r <= 1'b0;
         lanes_r <= '0;
      end else begin
         ramp_r <= ramp_nxt;
         alt_r <= alt_nxt;
         active_r <= active_nxt;
         lanes_r <= lanes_nxt;
      end
   end

   assign PATTERN_ACTIVE = active_r;

   // ----------------------------------------------------------
   // Link clock side
   // ----------------------------------------------------------
   logic link_rst_s1_r;
   logic link_rst_r;

   always_ff @(posedge LINK_CLOCK) begin
      link_rst_s1_r <= RST;
      link_rst_r <= link_rst_s1_r;
   end

   word_crossing #(
      .W(32)
   ) u_cross (
      .src_clk(CLOCK),
      .src_rst(RST),
      .src_word(lanes_r),
      .dst_clk(LINK_CLOCK),
      .dst_rst(link_rst_r),
      .dst_word_r(LANE_OUT),
      .dst_new(LANE_NEW)
   );

endmodule
`default_nettype wire

// ---- src/adc_post_cfg.svh ----
// Register map, field positions and reset values of the post stage
`ifndef ADC_POST_CFG_SVH
`define ADC_POST_CFG_SVH

// -------------------------------------------------------------
// Register addresses
// -------------------------------------------------------------
`define ADDR_SWAP 8'h24
`define ADDR_PATSEL 8'h25
`define ADDR_PAT1 8'h26
`define ADDR_PAT2 8'h27
`define ADDR_COARSE 8'h2B
`define ADDR_GAINCFG 8'h33
`define ADDR_TRIM_LO 8'h34
`define ADDR_TRIM_HI 8'h37

// -------------------------------------------------------------
// Field positions
// -------------------------------------------------------------
`define SWAP_DUAL_LSB 4
`define SWAP_DUAL_MSB 5
`define SWAP_SINGLE_BIT 6
`define PATSEL_LSB 4
`define PATSEL_MSB 6
`define PATCODE_LSB 8
`define PATCODE_MSB 15
`define COARSE_D1_LSB 0
`define COARSE_D2_LSB 4
`define COARSE_S_LSB 8
`define COARSE_W 4
`define GAINCFG_STEP_BIT 0
`define GAINCFG_TRIM_BIT 1
`define TRIM_ODD_LSB 0
`define TRIM_EVEN_LSB 8
`define TRIM_W 7

// -------------------------------------------------------------
// Reset values and codes
// -------------------------------------------------------------
`define PATSEL_RESET 3'h7
`define PATSEL_RAMP 3'h4
`define PATSEL_ALT 3'h2
`define CODE_RESET 8'h00
`define COARSE_RESET 4'h0
`define TRIM_RESET 7'h00
`define TRIM_UNITY 14'h2000
`define CODE_MID 8'h80
`define CODE_FULL 8'hFF

// -------------------------------------------------------------
// Serial control frame
// -------------------------------------------------------------
`define SPI_FRAME_BITS 24
`define SPI_ADDR_LSB 16
`define SPI_COUNT_MAX 5'h1F

`endif

// ---- src/adc_post_pkg.sv ----
// Types shared by the post-conversion stage
`default_nettype none
package adc_post_pkg;

   typedef struct packed {
      logic [2:0] branch;
      logic [7:0] code;
   } lane_sample_t;

   typedef lane_sample_t [3:0] lane_set_t;

   typedef logic [3:0][7:0] lane_codes_t;

   typedef struct packed {
      logic step_x;
      logic trim_en;
      logic [3:0] coarse;
      logic swap;
   } lane_ctrl_t;

   typedef enum logic [2:0] {
      PAT_NORMAL = 3'h1,
      PAT_RAMP = 3'h2,
      PAT_ALT = 3'h4
   } pattern_mode_t;

   typedef enum logic [1:0] {
      SPI_IDLE = 2'h1,
      SPI_SHIFT = 2'h2
   } spi_state_t;

endpackage
`default_nettype wire

// ---- src/gain_stage.sv ----
// One lane: input swap, coarse gain, branch trim and clamp
`timescale 1ns/1ps
`default_nettype none
`include "adc_post_cfg.svh"

module gain_stage #(
   parameter int CODE_W = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire adc_post_pkg::lane_ctrl_t ctrl,
   input wire logic [`TRIM_W-1:0] trim,
   input wire logic [CODE_W-1:0] code_in,
   output logic [CODE_W-1:0] code_r
);

   if (CODE_W != 8) $error("gain_stage serves 8-bit codes only");

   // Coarse factor in Q8; unused codes fall back to unity
   function automatic logic [13:0] coarse_q8(input logic step_x,
                                             input logic [3:0] c);
      logic [13:0] f;
      f = 14'h0100;
      if (step_x) begin
         unique case (c)
            4'h1: f = 14'h0140;
            4'h2: f = 14'h0200;
            4'h3: f = 14'h0280;
            4'h4: f = 14'h0400;
            4'h5: f = 14'h0500;
            4'h6: f = 14'h0800;
            4'h7: f = 14'h0A00;
            4'h8: f = 14'h0C80;
            4'h9: f = 14'h1000;
            4'hA: f = 14'h1400;
            4'hB: f = 14'h1900;
            4'hC: f = 14'h2000;
            4'hD: f = 14'h3200;
            default: f = 14'h0100;
         endcase
      end else begin
         unique case (c)
            4'h1: f = 14'h011F;
            4'h2: f = 14'h0142;
            4'h3: f = 14'h016A;
            4'h4: f = 14'h0196;
            4'h5: f = 14'h01C7;
            4'h6: f = 14'h01FF;
            4'h7: f = 14'h023D;
            4'h8: f = 14'h0283;
            4'h9: f = 14'h02D2;
            4'hA: f = 14'h032A;
            4'hB: f = 14'h038C;
            4'hC: f = 14'h03FB;
            default: f = 14'h0100;
         endcase
      end
      return f;
   endfunction

   logic [CODE_W-1:0] code_nxt;
   logic [CODE_W-1:0] sw;
   logic [13:0] trim_q13;
   logic signed [9:0] diff;
   logic signed [24:0] p1;
   logic signed [31:0] p2;
   logic signed [18:0] sum;

   always_comb begin
      sw = ctrl.swap ? ~code_in : code_in;
      diff = $signed({2'b00, sw}) - $signed({2'b00, `CODE_MID});
      p1 = diff * $signed({1'b0, coarse_q8(ctrl.step_x, ctrl.coarse)});
      trim_q13 = `TRIM_UNITY;
      if (ctrl.trim_en) begin
         if (trim[`TRIM_W-1]) begin
            trim_q13 = `TRIM_UNITY - {8'h00, ~trim[5:0]};
         end else begin
            trim_q13 = `TRIM_UNITY + {8'h00, trim[5:0]};
         end
      end
      p2 = $signed(p1[24:8]) * $signed({1'b0, trim_q13});
      sum = $signed(p2[31:13]) + $signed({11'h000, `CODE_MID});
      if (sum < 0) begin
         code_nxt = '0;
      end else if (sum > $signed({11'h000, `CODE_FULL})) begin
         code_nxt = `CODE_FULL;
      end else begin
         code_nxt = sum[CODE_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         code_r <= '0;
      end else begin
         code_r <= code_nxt;
      end
   end

endmodule
`default_nettype wire

// ---- src/word_crossing.sv ----
// Ping-pong word crossing from the sample clock to the link clock
`timescale 1ns/1ps
`default_nettype none

module word_crossing #(
   parameter int W = 32
) (
   input wire logic src_clk,
   input wire logic src_rst,
   input wire logic [W-1:0] src_word,
   input wire logic dst_clk,
   input wire logic dst_rst,
   output logic [W-1:0] dst_word_r,
   output logic dst_new
);

   if (W < 1) $error("word_crossing needs a positive width");

   // Each slot stays still for two source cycles while it is read
   logic [1:0][W-1:0] slot_r, slot_nxt;
   logic last_r, last_nxt;
   logic s1_r, s2_r, s3_r;
   logic [W-1:0] word_nxt;

   always_comb begin
      slot_nxt = slot_r;
      last_nxt = ~last_r;
      slot_nxt[~last_r] = src_word;
   end

   always_ff @(posedge src_clk) begin
      if (src_rst) begin
         slot_r <= '0;
         last_r <= 1'b0;
      end else begin
         slot_r <= slot_nxt;
         last_r <= last_nxt;
      end
   end

   always_comb begin
      dst_new = s2_r ^ s3_r;
      word_nxt = dst_new ? slot_r[s2_r] : dst_word_r;
   end

   always_ff @(posedge dst_clk) begin
      if (dst_rst) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         dst_word_r <= '0;
      end else begin
         s1_r <= last_r;
         s2_r <= s1_r;
         s3_r <= s2_r;
         dst_word_r <= word_nxt;
      end
   end

endmodule
`default_nettype wire

// ---- tb/adc_post_top_monitor.sv ----
// Concurrent checks on the ports of the post-conversion stage
`timescale 1ns/1ps
`default_nettype none

module adc_post_top_monitor #(
   parameter int BRANCHES = 8,
   parameter int LANES = 4
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic SCTRL_SEL_N,
   input wire logic SCTRL_CLK,
   input wire logic SCTRL_DATA,
   input wire logic SINGLE_MODE,
   input wire adc_post_pkg::lane_set_t SAMPLE_IN,
   input wire logic LINK_CLOCK,
   input wire adc_post_pkg::lane_codes_t LANE_OUT,
   input wire logic LANE_NEW,
   input wire logic [1:0] DUAL_INPUT_SWAP,
   input wire logic SINGLE_INPUT_SWAP,
   input wire logic PATTERN_ACTIVE
);
   logic [3:0] pat_cnt_r;
   logic [3:0] pat_cnt_nxt;
   logic [2:0] swaps;

   assign swaps = {DUAL_INPUT_SWAP, SINGLE_INPUT_SWAP};

   // Cycles the pattern has been active, saturating
   always_comb begin
      pat_cnt_nxt = pat_cnt_r;
      if (!PATTERN_ACTIVE) begin
         pat_cnt_nxt = 4'h0;
      end else if (pat_cnt_r != 4'hF) begin
         pat_cnt_nxt = pat_cnt_r + 4'h1;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         pat_cnt_r <= 4'h0;
      end else begin
         pat_cnt_r <= pat_cnt_nxt;
      end
   end

   a_reset_clears: assert property (
      @(posedge CLOCK) disable iff (RST)
      $fell(RST) |-> swaps == 3'h0 && !PATTERN_ACTIVE)
      else $error("outputs not cleared by reset");
   a_swap_after_frame: assert property (
      @(posedge CLOCK) disable iff (RST)
      $changed(swaps) |-> SCTRL_SEL_N && $past(SCTRL_SEL_N, 3))
      else $error("swap bits changed outside a commit");
   a_pattern_after_frame: assert property (
      @(posedge CLOCK) disable iff (RST)
      $changed(PATTERN_ACTIVE) |-> SCTRL_SEL_N && $past(SCTRL_SEL_N, 3))
      else $error("pattern flag changed outside a commit");
   a_quiet_in_frame: assert property (
      @(posedge CLOCK) disable iff (RST)
      (!SCTRL_SEL_N) [*6] |-> $stable({swaps, PATTERN_ACTIVE}))
      else $error("settings moved during a frame");
   a_new_single: assert property (
      @(posedge LINK_CLOCK) disable iff (RST)
      LANE_NEW |=> !LANE_NEW)
      else $error("lane strobe longer than one cycle");
   a_out_holds: assert property (
      @(posedge LINK_CLOCK) disable iff (RST)
      $changed(LANE_OUT) |-> $past(LANE_NEW))
      else $error("lane word changed without strobe");
   a_pattern_lanes: assert property (
      @(posedge LINK_CLOCK) disable iff (RST)
      pat_cnt_r == 4'hF && LANE_NEW |=> LANE_OUT[0] == LANE_OUT[1]
         && LANE_OUT[0] == LANE_OUT[2] && LANE_OUT[0] == LANE_OUT[3])
      else $error("lanes differ under a test pattern");
   a_link_reset_zero: assert property (
      @(posedge LINK_CLOCK) disable iff (RST)
      $fell(RST) |-> LANE_OUT == '0 && !LANE_NEW)
      else $error("lane word not cleared by reset");

   c_pattern_on: cover property (@(posedge CLOCK) $rose(PATTERN_ACTIVE));
   c_both_swaps: cover property (@(posedge CLOCK) DUAL_INPUT_SWAP == 2'h3);
   c_full_scale: cover property (@(posedge LINK_CLOCK)
      LANE_NEW && LANE_OUT[0] == 8'hFF);
endmodule

`default_nettype wire

// ---- tb/fpga_lane_receiver.sv ----
// Receiver logic on the link side that captures each delivered lane word
`timescale 1ns/1ps
`default_nettype none

module fpga_lane_receiver (
   input wire logic link_clk,
   input wire adc_post_pkg::lane_codes_t lane_out,
   input wire logic lane_new,
   output var adc_post_pkg::lane_codes_t word_r,
   output logic got_r
);
   logic cap_r;

   // Word is valid two edges after the strobe
   always_ff @(posedge link_clk) begin
      cap_r <= lane_new;
      got_r <= cap_r;
      if (cap_r) begin
         word_r <= lane_out;
      end
   end
endmodule

`default_nettype wire

// ---- tb/test_adc_post_top.sv ----
// Self-checking bench for the post-conversion stage
`timescale 1ns/1ps
`default_nettype none
`include "adc_post_cfg.svh"

module test_adc_post_top;
   localparam int BRANCHES = 8;
   localparam int LANES = 4;
   localparam int XG [16] = '{256, 320, 512, 640, 1024, 1280, 2048, 2560,
      3200, 4096, 5120, 6400, 8192, 12800, 256, 256};
   localparam int DG [16] = '{256, 287, 322, 362, 406, 455, 511, 573,
      643, 722, 810, 908, 1019, 256, 256, 256};
   logic clock = 1'h0;
   logic link_clk = 1'h0;
   logic rst = 1'h1;
   logic sel_n = 1'h1;
   logic sclk = 1'h0;
   logic sdata = 1'h0;
   logic single = 1'h0;
   adc_post_pkg::lane_set_t samples = '0;
   adc_post_pkg::lane_codes_t lanes;
   adc_post_pkg::lane_codes_t word;
   logic lane_new;
   logic got;
   logic pat_act;
   logic sswap;
   logic [1:0] dswap;
   adc_post_pkg::lane_codes_t expq [$];
   int miscompares = 0;
   int compares = 0;
   int mode = 0;
   int seen2 = 0;
   logic started;
   logic [7:0] prev;
   logic [7:0] nxt;
   logic [7:0] c1;
   logic [7:0] c2;
   logic [3:0] crs [3];
   logic [6:0] trims [8];
   logic step = 1'h0;
   logic trim_en = 1'h0;
   logic [2:0] swp = 3'h0;

   initial forever #50 clock = ~clock;
   initial begin
      #7;
      forever #24 link_clk = ~link_clk;
   end

   adc_post_top #(.BRANCHES(BRANCHES), .LANES(LANES)) u_adc_post_top (
      .CLOCK(clock), .RST(rst), .SCTRL_SEL_N(sel_n), .SCTRL_CLK(sclk),
      .SCTRL_DATA(sdata), .SINGLE_MODE(single), .SAMPLE_IN(samples),
      .LINK_CLOCK(link_clk), .LANE_OUT(lanes), .LANE_NEW(lane_new),
      .DUAL_INPUT_SWAP(dswap), .SINGLE_INPUT_SWAP(sswap),
      .PATTERN_ACTIVE(pat_act));
   fpga_lane_receiver u_fpga_lane_receiver (.link_clk(link_clk),
      .lane_out(lanes), .lane_new(lane_new), .word_r(word), .got_r(got));

   task automatic check_word(input adc_post_pkg::lane_codes_t g, e);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %0t lanes %h expected %h", $time, g, e);
      end
   endtask

   task automatic check_bits(input logic [3:0] g, e);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %0t flags %h expected %h", $time, g, e);
      end
   endtask

   task automatic stop_test();
      if (miscompares == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Serial write, n bits of {address, data} sent MSB first
   task automatic spi(input logic [7:0] a, input logic [15:0] d, input int n);
      logic [23:0] w;
      w = {a, d};
      @(posedge clock);
      sel_n <= 1'h0;
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         sdata <= w[23 - i];
         repeat (3) @(posedge clock);
         sclk <= 1'h1;
         repeat (3) @(posedge clock);
         sclk <= 1'h0;
      end
      repeat (3) @(posedge clock);
      sel_n <= 1'h1;
      sdata <= ~sdata;
      repeat (8) @(posedge clock);
   endtask

   function automatic logic [7:0] gain_exp(input logic [7:0] code,
         input int ch, input logic sw, input logic [6:0] t);
      int s;
      int c;
      int tt;
      int v;
      logic [5:0] inv;
      inv = ~t[5:0];
      s = sw ? 255 - code : code;
      c = step ? XG[crs[ch]] : DG[crs[ch]];
      tt = !trim_en ? 8192 : (t[6] ? 8192 - inv : 8192 + t[5:0]);
      v = 128 + ((((s - 128) * c) >>> 8) * tt >>> 13);
      return v < 0 ? 8'h00 : (v > 255 ? 8'hFF : v[7:0]);
   endfunction

   task automatic run_gain(input bit do_cfg);
      adc_post_pkg::lane_set_t ns;
      adc_post_pkg::lane_codes_t e;
      logic sm;
      int ch;
      if (do_cfg) begin
         spi(`ADDR_GAINCFG, {14'h0, trim_en, step}, 24);
         spi(`ADDR_COARSE, {4'h0, crs[2], crs[1], crs[0]}, 24);
         for (int k = 0; k < 4; k++) begin
            spi(8'(`ADDR_TRIM_LO + k), {1'h0, trims[2 * k + 1], 1'h0,
               trims[2 * k]}, 24);
         end
         spi(`ADDR_SWAP, {9'h0, swp, 4'h0}, 24);
      end
      sm = 1'($urandom);
      ns = adc_post_pkg::lane_set_t'(44'({$urandom, $urandom}));
      for (int g = 0; g < 4; g++) begin
         ch = sm ? 2 : g / 2;
         e[g] = gain_exp(ns[g].code, ch, swp[ch], trims[ns[g].branch]);
      end
      @(posedge clock);
      single <= sm;
      samples <= ns;
      repeat (20) @(posedge clock);
      expq.push_back(e);
      for (int n = 0; n < 50 && expq.size() > 0; n++) @(posedge clock);
      check_bits(4'(expq.size()), 4'h0);
      check_bits({dswap, sswap, pat_act}, {swp[1:0], swp[2], 1'h0});
   endtask

   // Result watcher: queued words, or the running pattern
   always @(posedge link_clk) begin
      if (got === 1'h1) begin
         if (mode == 1 && (started || word !== {4{8'h80}})) begin
            nxt = prev + 8'h01;
            check_word(word, {4{nxt}});
            prev = nxt;
            started = 1'h1;
         end else if (mode == 2) begin
            nxt = (started && prev === c1) ? c2 : c1;
            nxt = (!started && word[0] === c2) ? c2 : nxt;
            check_word(word, {4{nxt}});
            seen2 += (nxt === c2 && c1 != c2);
            prev = nxt;
            started = 1'h1;
         end else if (mode == 0 && expq.size() > 0) begin
            check_word(word, expq.pop_front());
         end
      end
   end

   initial begin
      #9_000_000;
      miscompares++;
      stop_test();
   end

   initial begin
      adc_post_pkg::lane_set_t ns;
      void'($urandom(32'h35e3b2a0));
      foreach (crs[k]) crs[k] = 4'h0;
      foreach (trims[k]) trims[k] = 7'($urandom);
      repeat (12) @(posedge clock);
      rst <= 1'h0;
      run_gain(1'b0);
      for (int i = 0; i < 32; i++) begin
         step = (i >= 16);
         crs[0] = 4'(i);
         crs[1] = 4'(i + 5);
         crs[2] = 4'(i + 9);
         trim_en = 1'($urandom);
         swp = 3'($urandom);
         foreach (trims[k]) trims[k] = 7'($urandom);
         run_gain(1'b1);
      end
      spi(`ADDR_SWAP, 16'h0000, 24);
      for (int g = 0; g < 4; g++) ns[g] = '{branch: 3'h0, code: 8'h80};
      samples <= ns;
      spi(`ADDR_PATSEL, 16'h0040, 23);
      spi(8'h30, 16'hFFFF, 24);
      check_bits({dswap, sswap, pat_act}, 4'h0);
      prev = 8'hFF;
      started = 1'h0;
      mode = 1;
      spi(`ADDR_PATSEL, 16'h0040, 24);
      repeat (600) @(posedge clock);
      mode = 0;
      check_bits({pat_act, started}, 2'h3);
      spi(`ADDR_PATSEL, 16'h0070, 24);
      c1 = 8'h00;
      c2 = 8'h00;
      spi(`ADDR_PATSEL, 16'h0020, 24);
      repeat (20) @(posedge clock);
      started = 1'h0;
      mode = 2;
      repeat (30) @(posedge clock);
      mode = 0;
      c1 = 8'($urandom);
      c2 = ~c1;
      spi(`ADDR_PAT1, {c1, 8'($urandom)}, 24);
      spi(`ADDR_PAT2, {c2, 8'($urandom)}, 24);
      repeat (20) @(posedge clock);
      started = 1'h0;
      mode = 2;
      repeat (200) @(posedge clock);
      mode = 0;
      check_bits(4'(seen2 > 0), 4'h1);
      spi(`ADDR_PATSEL, 16'h0070, 24);
      check_bits({3'h0, pat_act}, 4'h0);
      stop_test();
   end
endmodule

bind adc_post_top adc_post_top_monitor #(.BRANCHES(BRANCHES), .LANES(LANES))
   u_monitor (.CLOCK(CLOCK), .RST(RST), .SCTRL_SEL_N(SCTRL_SEL_N),
   .SCTRL_CLK(SCTRL_CLK), .SCTRL_DATA(SCTRL_DATA),
   .SINGLE_MODE(SINGLE_MODE), .SAMPLE_IN(SAMPLE_IN),
   .LINK_CLOCK(LINK_CLOCK), .LANE_OUT(LANE_OUT), .LANE_NEW(LANE_NEW),
   .DUAL_INPUT_SWAP(DUAL_INPUT_SWAP), .SINGLE_INPUT_SWAP(SINGLE_INPUT_SWAP),
   .PATTERN_ACTIVE(PATTERN_ACTIVE));

`default_nettype wire
